// *** hw/dpa_pkg.sv ***
package dpa_pkg;

	// ----------------------------------------------------------------
	// Register map (printed offsets are indices; byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_OUTPUT_ADJUST = 12'h031;
	localparam logic [11:0] IDX_HOUSEKEEPING  = 12'h032;
	localparam logic [11:0] IDX_EVENT_STATUS  = 12'h040;
	localparam logic [11:0] IDX_EVENT_MASK    = 12'h041;
	localparam logic [11:0] IDX_LOOP_MODE     = 12'h042;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int POW_LSB  = 3;
	localparam int POW_MSB  = 9;
	localparam int POW_W    = 7;
	localparam int SKEW_LSB = 0;
	localparam int SKEW_MSB = 2;
	localparam int SKEW_W   = 3;
	localparam int ADJ_W    = 10;
	localparam int SFD_BIT  = 5;
	localparam int PFD_BIT  = 4;
	localparam int LMT_BIT  = 3;
	localparam int STATE_W  = 3;
	localparam int HK_W     = 6;
	localparam int EV_W     = 3;
	localparam int MODE_W   = 2;

	localparam logic [ADJ_W-1:0]  ADJ_RESET  = 10'h000;
	localparam logic [EV_W-1:0]   MASK_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Loop modes and step sizes (ps)
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DPA_MODE_NORMAL,
		DPA_MODE_HOLDOVER,
		DPA_MODE_FREERUN,
		DPA_MODE_BYPASS
	} dpa_mode_t;

	localparam int STEP_PS_FAST = 15200;
	localparam int STEP_PS_T1   = 20200;
	localparam int SKEW_STEP_PS = 1900;

endpackage

// *** hw/dpa_output_adjust.sv ***
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - bits 9..3 are signed phase offset
// - positive leads, negative lags, streams follow
// - step 15.2ns, or 20.2ns at 1.544MHz
// - bits 2..0 skew delay, 1.9ns steps
// - offset and skew ignored in freerun/bypass
// - bit 5 high when secondary reference fails
// - bit 4 high when selected primary fails
// - bit 3 high while slope limiter acts
// - bits 2..0 report loop state number
module dpa_output_adjust (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [13:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Loop status from the reference monitors and state machine
	input  wire logic        secondary_timing_input_fail,
	input  wire logic        pri_ref_fail_a,
	input  wire logic        pri_ref_fail_b,
	input  wire logic        primary_ref_select,
	input  wire logic        slope_limit_active,
	input  wire logic [2:0]  pll_state_in,
	input  wire logic        ref_is_1544,
	// Adjustment applied to the loop outputs
	output logic signed [6:0] phase_offset_applied,
	output logic        [2:0] skew_applied,
	output logic       [15:0] phase_offset_ps,
	output logic       [15:0] skew_delay_ps,
	output logic              phase_lead,
	output logic              phase_lag,
	// Interrupt
	output logic              irq
);

	// ----------------------------------------------------------------
	// Input synchronisers: status lines arrive from reference logic
	// ----------------------------------------------------------------
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] raw_in;

	assign raw_in = {ref_is_1544, pll_state_in, slope_limit_active,
		secondary_timing_input_fail, pri_ref_fail_b, pri_ref_fail_a};

	// Reset clears both stages so no false event follows reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync1_r <= 8'h00;
		end else begin
			sync1_r <= raw_in;
		end
	end

	// Stage one feeds nothing but stage two
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync2_r <= 8'h00;
		end else begin
			sync2_r <= sync1_r;
		end
	end

	logic       pri_fail_a_s;
	logic       pri_fail_b_s;
	logic       sec_fail_s;
	logic       limit_s;
	logic [2:0] state_s;
	logic       ref_1544_s;

	assign pri_fail_a_s = sync2_r[0];
	assign pri_fail_b_s = sync2_r[1];
	assign sec_fail_s   = sync2_r[2];
	assign limit_s      = sync2_r[3];
	assign state_s      = sync2_r[6:4];
	assign ref_1544_s   = sync2_r[7];

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic [11:0] word_idx;
	logic        acc;
	logic        wr_acc;
	logic        rd_acc;
	logic        hit_adj;
	logic        hit_hk;
	logic        hit_st;
	logic        hit_msk;
	logic        hit_mode;
	logic        mapped;
	logic        aligned;

	assign word_idx = paddr[13:2];
	assign acc      = psel && penable;
	assign wr_acc   = acc && pwrite;
	assign rd_acc   = acc && !pwrite;
	assign hit_adj  = word_idx == dpa_pkg::IDX_OUTPUT_ADJUST;
	assign hit_hk   = word_idx == dpa_pkg::IDX_HOUSEKEEPING;
	assign hit_st   = word_idx == dpa_pkg::IDX_EVENT_STATUS;
	assign hit_msk  = word_idx == dpa_pkg::IDX_EVENT_MASK;
	assign hit_mode = word_idx == dpa_pkg::IDX_LOOP_MODE;
	assign mapped   = hit_adj || hit_hk || hit_st || hit_msk || hit_mode;
	assign aligned  = paddr[1:0] == 2'h0;

	// Zero wait states; unmapped or misaligned addresses answer with an error
	// Misaligned accesses are refused so a byte lane cannot alias a register
	assign pready  = 1'b1;
	assign pslverr = acc && (!mapped || !aligned);

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	logic [dpa_pkg::ADJ_W-1:0]  adjust_r;
	logic [dpa_pkg::EV_W-1:0]   mask_r;
	// Loop mode is held here to gate the adjustment and is read back at IDX_LOOP_MODE
	dpa_pkg::dpa_mode_t         mode_r;

	// Upper bits 31..10 are not stored, so stray ones cannot reach the loop
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			adjust_r <= dpa_pkg::ADJ_RESET;
		end else if (wr_acc && hit_adj && aligned) begin
			adjust_r <= pwdata[dpa_pkg::ADJ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mask_r <= dpa_pkg::MASK_RESET;
		end else if (wr_acc && hit_msk && aligned) begin
			mask_r <= pwdata[dpa_pkg::EV_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_r <= dpa_pkg::DPA_MODE_NORMAL;
		end else if (wr_acc && hit_mode && aligned) begin
			mode_r <= dpa_pkg::dpa_mode_t'(pwdata[dpa_pkg::MODE_W-1:0]);
		end
	end

	// ----------------------------------------------------------------
	// Primary reference selection, synchronised like the status lines
	// ----------------------------------------------------------------
	logic       primary_ref_select_s;
	logic [1:0] psel_sync_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			psel_sync_r <= 2'h0;
		end else begin
			psel_sync_r <= {psel_sync_r[0], primary_ref_select};
		end
	end

	assign primary_ref_select_s = psel_sync_r[1];

	// ----------------------------------------------------------------
	// Live housekeeping status; no write path exists into it
	// ----------------------------------------------------------------
	// The state code is synchronised bit by bit, so a read taken while
	// the loop changes state may show a mixed code for one cycle
	logic                      pri_fail_sel;
	logic [dpa_pkg::HK_W-1:0]  hk_live;

	assign pri_fail_sel = primary_ref_select_s ? pri_fail_b_s : pri_fail_a_s;

	always_comb begin
		hk_live = '0;
		hk_live[dpa_pkg::SFD_BIT] = sec_fail_s;
		hk_live[dpa_pkg::PFD_BIT] = pri_fail_sel;
		hk_live[dpa_pkg::LMT_BIT] = limit_s;
		hk_live[dpa_pkg::STATE_W-1:0] = state_s;
	end

	// ----------------------------------------------------------------
	// Event flags: rising fail/limit conditions, cleared by status read
	// ----------------------------------------------------------------
	logic [dpa_pkg::EV_W-1:0] ev_prev_r;
	logic [dpa_pkg::EV_W-1:0] ev_now;
	logic [dpa_pkg::EV_W-1:0] ev_rise;
	logic [dpa_pkg::EV_W-1:0] ev_status_r;
	logic                     st_read;
	logic [dpa_pkg::EV_W-1:0] ev_status_nxt;

	// Rising edges only: a fail that stays up raises one event, not many
	assign ev_now  = {limit_s, pri_fail_sel, sec_fail_s};
	assign ev_rise = ev_now & ~ev_prev_r;
	assign st_read = rd_acc && hit_st && aligned;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ev_prev_r <= '0;
		end else begin
			ev_prev_r <= ev_now;
		end
	end

	// A new event in the clearing cycle survives the read
	always_comb begin
		ev_status_nxt = ev_status_r;
		if (st_read) begin
			ev_status_nxt = '0;
		end
		ev_status_nxt = ev_status_nxt | ev_rise;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ev_status_r <= '0;
		end else begin
			ev_status_r <= ev_status_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ev_status_nxt & mask_r);
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Reads outside an access phase return zero so the bus shows no stale data
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_acc && aligned) begin
			if (hit_adj) begin
				prdata[dpa_pkg::ADJ_W-1:0] = adjust_r;
			end else if (hit_hk) begin
				prdata[dpa_pkg::HK_W-1:0] = hk_live;
			end else if (hit_st) begin
				prdata[dpa_pkg::EV_W-1:0] = ev_status_r;
			end else if (hit_msk) begin
				prdata[dpa_pkg::EV_W-1:0] = mask_r;
			end else if (hit_mode) begin
				prdata[dpa_pkg::MODE_W-1:0] = mode_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Adjustment applied to the loop outputs
	// ----------------------------------------------------------------
	// Offset magnitude (max 64 steps of the long step) is shown in 100 ps units
	localparam int OFFSET_UNIT_PS = 100;

	logic                      adj_active;
	logic signed [6:0]         pow;
	logic        [6:0]         pow_mag;
	logic        [2:0]         skew;
	logic        [31:0]        step_ps;
	logic        [31:0]        off_ps_full;
	logic        [31:0]        skew_ps_full;

	assign adj_active = !(mode_r == dpa_pkg::DPA_MODE_FREERUN ||
		mode_r == dpa_pkg::DPA_MODE_BYPASS);
	assign pow     = adjust_r[dpa_pkg::POW_MSB:dpa_pkg::POW_LSB];
	// The most negative word still fits seven bits as a magnitude
	assign pow_mag = pow[6] ? 7'(-pow) : 7'(pow);
	assign skew    = adjust_r[dpa_pkg::SKEW_MSB:dpa_pkg::SKEW_LSB];
	// Step follows the live reference rate, so a rate change rescales the offset
	assign step_ps = ref_1544_s ? 32'(dpa_pkg::STEP_PS_T1) : 32'(dpa_pkg::STEP_PS_FAST);
	assign off_ps_full  = 32'(pow_mag) * step_ps;
	assign skew_ps_full = 32'(skew) * 32'(dpa_pkg::SKEW_STEP_PS);

	// Applied values are registered so the loop sees one coherent update;
	// in freerun or bypass every applied value falls back to zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_offset_applied <= '0;
		end else if (adj_active) begin
			phase_offset_applied <= pow;
		end else begin
			phase_offset_applied <= '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			skew_applied <= '0;
		end else if (adj_active) begin
			skew_applied <= skew;
		end else begin
			skew_applied <= '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_offset_ps <= '0;
		end else if (adj_active) begin
			phase_offset_ps <= 16'(off_ps_full / 32'(OFFSET_UNIT_PS));
		end else begin
			phase_offset_ps <= '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			skew_delay_ps <= '0;
		end else if (adj_active) begin
			skew_delay_ps <= 16'(skew_ps_full);
		end else begin
			skew_delay_ps <= '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_lead <= 1'b0;
		end else if (adj_active) begin
			phase_lead <= !pow[6] && pow != 7'sh00;
		end else begin
			phase_lead <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_lag <= 1'b0;
		end else if (adj_active) begin
			phase_lag <= pow[6];
		end else begin
			phase_lag <= 1'b0;
		end
	end

endmodule

// *** dv/dpa_ref_src.sv ***
`timescale 1ns/1ps
// Reference monitors and loop state machine as seen by the block
module dpa_ref_src (
	// Clock and requested condition
	input  wire logic       clk_sys,
	input  wire logic [8:0] cond,
	// Status levels
	output logic            ref_is_1544,
	output logic            secondary_timing_input_fail,
	output logic            pri_ref_fail_a,
	output logic            pri_ref_fail_b,
	output logic            primary_ref_select,
	output logic            slope_limit_active,
	output logic [2:0]      pll_state_in
);
	logic [8:0] cond_r = 9'h000;
	// Conditions change just after an edge, unrelated to any bus cycle
	always @(posedge clk_sys) cond_r <= cond;
	assign {ref_is_1544, secondary_timing_input_fail, pri_ref_fail_a, pri_ref_fail_b, primary_ref_select,
		slope_limit_active, pll_state_in} = cond_r;
endmodule

// *** dv/dpa_output_adjust_chk.sv ***
`timescale 1ns/1ps
module dpa_output_adjust_chk (
	// APB
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Status and applied adjustment
	input wire logic        secondary_timing_input_fail,
	input wire logic        pri_ref_fail_a,
	input wire logic        pri_ref_fail_b,
	input wire logic        primary_ref_select,
	input wire logic        slope_limit_active,
	input wire logic [2:0]  pll_state_in,
	input wire logic signed [6:0] phase_offset_applied,
	input wire logic [2:0]  skew_applied,
	input wire logic [15:0] skew_delay_ps,
	input wire logic        phase_lead,
	input wire logic        phase_lag
);
	logic [7:0] st_prev_r;
	logic [1:0] st_age_r;
	logic [9:0] wadj_r;
	wire  [7:0] st_now = {secondary_timing_input_fail, pri_ref_fail_a, pri_ref_fail_b, primary_ref_select,
		slope_limit_active, pll_state_in};
	wire        acc = psel && penable;
	wire        rd_hk = acc && !pwrite && paddr == 14'h00C8;
	wire        wr_adj = acc && pwrite && paddr == 14'h00C4;
	// Status is judged only once the input synchronisers have settled
	always_ff @(posedge clk_sys) begin
		st_prev_r <= st_now;
		if (rst || st_now != st_prev_r)
			st_age_r <= 2'h0;
		else if (st_age_r != 2'h3)
			st_age_r <= st_age_r + 2'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (wr_adj)
			wadj_r <= pwdata[9:0];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_lead_sign: assert property (phase_lead == (phase_offset_applied > 0))
		else $error("lead flag wrong");
	a_lag_sign: assert property (phase_lag == (phase_offset_applied < 0))
		else $error("lag flag wrong");
	a_skew_ps: assert property (skew_delay_ps == 16'(skew_applied) * 16'h076C)
		else $error("skew delay wrong");
	a_adj_clean: assert property (acc && !pwrite && paddr == 14'h00C4 |-> !prdata[31:10])
		else $error("adjustment upper bits set");
	a_hk_fields: assert property (rd_hk && st_age_r == 2'h3 |-> prdata == {26'h0, secondary_timing_input_fail,
		primary_ref_select ? pri_ref_fail_b : pri_ref_fail_a, slope_limit_active, pll_state_in})
		else $error("housekeeping status wrong");
	a_hk_wr_ok: assert property (acc && pwrite && paddr == 14'h00C8 |-> !pslverr)
		else $error("housekeeping write refused");
	a_skew_apply: assert property (wr_adj |-> ##2 skew_applied == wadj_r[2:0] || !skew_applied)
		else $error("skew not applied");
	a_pos_apply: assert property (wr_adj |-> ##2 (phase_offset_applied == wadj_r[9:3]
		|| !phase_offset_applied)) else $error("offset not applied");
endmodule

// *** dv/dpa_output_adjust_tb.sv ***
`timescale 1ns/1ps
module dpa_output_adjust_tb;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rnd = 32'h51A6;
	logic        pready, pslverr, irq, phase_lead, phase_lag, ref_is_1544, secondary_timing_input_fail;
	logic        pri_ref_fail_a, pri_ref_fail_b, primary_ref_select, slope_limit_active;
	logic [2:0]  pll_state_in, skew_applied;
	logic signed [6:0] phase_offset_applied, po;
	logic [15:0] phase_offset_ps, skew_delay_ps;
	logic [9:0]  w;
	logic [8:0]  cond = 9'h000;
	logic [65:0] notes[$];
	int          error_cnt = 0;
	int          checks = 0;
	dpa_output_adjust dpa_output_adjust_i (.*);
	dpa_ref_src dpa_ref_src_i (.*);
	always #10 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Request is held until pready is seen; psel stays up so transfers can run back to back
	task automatic xfer(input logic wr, input logic [13:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
	endtask
	task automatic rd(input logic [13:0] a, input logic [32:0] msk, input logic [32:0] ex);
		notes.push_back({msk, ex});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic chk(input logic ok);
		checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("unexpected at %0t: mismatch", $time);
		end
	endtask
	task automatic conclude();
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		logic [65:0] n;
		if (psel && penable && !pwrite && pready) begin
			n = notes.pop_front();
			chk((({pslverr, prdata} ^ n[32:0]) & n[65:33]) === 33'h0);
		end
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(14'h00C4, {33{1'b1}}, 33'h0);
		for (int i = 0; i < 6; i++) begin
			rnd = xs(rnd);
			cond <= rnd[8:0];
			xfer(1'b1, 14'h00C8, {26'h0, ~rnd[5:0]});
			idle(6);
			rd(14'h00C8, {33{1'b1}}, {27'h0, rnd[7], rnd[4] ? rnd[5] : rnd[6], rnd[3], rnd[2:0]});
		end
		for (int i = 0; i < 12; i++) begin
			rnd = xs(rnd);
			w = (i % 3 == 0) ? 10'h1FF : (i % 3 == 1) ? 10'h200 : rnd[9:0];
			cond <= {rnd[0], 8'h00};
			xfer(1'b1, 14'h0108, 32'(i / 3));
			xfer(1'b1, 14'h00C4, {22'h0, w});
			idle(4);
			po = (i >= 6) ? 7'h00 : w[9:3];
			rd(14'h00C4, {33{1'b1}}, {23'h0, w});
			chk(phase_offset_applied === po && skew_applied === (i >= 6 ? 3'h0 : w[2:0]));
			chk(phase_lead === (po > 0) && phase_lag === (po < 0));
			chk(phase_offset_ps === 16'((po < 0 ? -int'(po) : int'(po)) * (rnd[0] ? 202 : 152)));
			chk(skew_delay_ps === 16'((i >= 6 ? 0 : int'(w[2:0])) * 1900));
		end
		xfer(1'b1, 14'h0108, 32'h0);
		rd(14'h0300, {33{1'b1}}, {1'b1, 32'h0});
		rd(14'h00C5, {33{1'b1}}, {1'b1, 32'h0});
		cond <= 9'h000;
		idle(8);
		rd(14'h0100, 33'h0, 33'h0);
		cond <= 9'h080;
		idle(8);
		chk(irq === 1'b0);
		xfer(1'b1, 14'h0104, 32'h1);
		idle(3);
		chk(irq === 1'b1);
		rd(14'h0100, {33{1'b1}}, 33'h1);
		rd(14'h0100, {33{1'b1}}, 33'h0);
		idle(3);
		chk(irq === 1'b0);
		conclude();
	end
	initial begin
		#100us;
		error_cnt++;
		conclude();
	end
endmodule
bind dpa_output_adjust dpa_output_adjust_chk dpa_output_adjust_chk_i (.*);
